// ---- hw/prch_handler.sv ----
// Purpose: Interprets single-shot and range page read requests.
// Assumes: Link layer strips CRC and checks MAC; memory answers reads in one cycle.
// Notes:   Frame check and MAC bytes are appended downstream on request.
// Function
// - Read4 request: 30h, page, MAC, CRC.
// - Read4 returns sixteen bytes, four pages.
// - Default start page range 00h to 3Bh.
// - Start page beyond limit gives NAK.
// - Span past end wraps to page 00h.
// - Active/traceable: start at boundary gives NAK.
// - Below boundary, wrap just before boundary page.
// - Secure messaging in traceable/auth requires MAC.
// - Authenticated state ignores protection boundary.
// - Key pages read back as 00h bytes.
// - Range request: 3Ah, first, last, MAC, CRC.
// - Range returns all pages inclusive, four bytes each.
// - First or last outside range gives NAK.
// - Last below first gives NAK.
// - Active/traceable: last at boundary gives NAK.
// - Range read needs MAC under secure messaging.
// - Authenticated range read skips boundary check.
// - Reply waits nine bit periods; reader timeout.
// - MAC present exactly when secure messaging on.
// - Requests and data responses end with CRC.
// - After NAK, deselect to idle or halt.
`default_nettype none
module prch_handler #(
  parameter logic [7:0] LAST_PAGE     = prch_pkg::PAGE_LAST,
  parameter logic [7:0] KEY_PAGE_LO   = 8'h30,
  parameter logic [7:0] KEY_PAGE_HI   = 8'h37,
  parameter int         FDT_WAIT      = prch_pkg::FDT_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       req_valid,
  input  wire logic [7:0] req_opcode,
  input  wire logic [7:0] first_page_arg,
  input  wire logic [7:0] last_page_arg,
  input  wire logic       req_mac_ok,
  input  wire logic [1:0] proto_state,
  input  wire logic       secure_msg_enable,
  input  wire logic [7:0] protect_boundary_page,
  output logic            busy,
  output logic [7:0]      mem_page,
  output logic [1:0]      mem_byte,
  output logic            mem_rd,
  input  wire logic [7:0] mem_rdata,
  output logic            rsp_valid,
  input  wire logic       rsp_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_last,
  output logic            rsp_append_mac,
  output logic            rsp_append_crc,
  output logic            nak_valid,
  output logic [3:0]      nak_code,
  output logic            deselect
);
  typedef enum logic [4:0] {
    PRCH_IDLE  = 5'b00001,
    PRCH_WAIT  = 5'b00010,
    PRCH_FETCH = 5'b00100,
    PRCH_PUSH  = 5'b01000,
    PRCH_DRAIN = 5'b10000
  } prch_state_t;

  prch_state_t state;
  prch_state_t next_state;
  logic [7:0]  page;
  logic [7:0]  pages_left;
  logic [1:0]  byte_idx;
  logic [7:0]  wrap_page;
  logic        do_nak;
  logic [23:0] wait_cnt;
  logic [7:0]  fetched;
  logic        fifo_ready;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        push;
  logic        last_byte_q;
  logic        last_flag [8];
  logic [2:0]  lf_wr;
  logic [2:0]  lf_rd;

  wire is_read4  = req_opcode == prch_pkg::OP_READ4;
  wire is_range  = req_opcode == prch_pkg::OP_READ_RANGE;
  wire authed    = proto_state == prch_pkg::ST_AUTH;
  wire guarded   = !authed && (protect_boundary_page <= LAST_PAGE);
  wire mac_need  = secure_msg_enable && proto_state != prch_pkg::ST_ACTIVE;
  wire mac_bad   = mac_need && !req_mac_ok;
  wire r4_bad    = first_page_arg > LAST_PAGE
                || (guarded && first_page_arg >= protect_boundary_page);
  wire rr_bad    = first_page_arg > LAST_PAGE || last_page_arg > LAST_PAGE
                || last_page_arg < first_page_arg
                || (guarded && last_page_arg >= protect_boundary_page);
  wire req_bad   = mac_bad || (is_read4 && r4_bad) || (is_range && rr_bad);
  wire req_ours  = req_valid && (is_read4 || is_range) && state == PRCH_IDLE;
  wire [7:0] lim = guarded ? protect_boundary_page - 8'h01 : LAST_PAGE;
  wire [7:0] cnt = is_read4 ? 8'(prch_pkg::PAGES_READ4)
                            : 8'(last_page_arg - first_page_arg + 8'h01);
  wire waited    = wait_cnt >= 24'(FDT_WAIT);
  wire key_page  = page >= KEY_PAGE_LO && page <= KEY_PAGE_HI;
  wire last_byte = pages_left == 8'h01 && byte_idx == 2'(prch_pkg::BYTES_PER_PAGE - 1);
  wire [7:0] next_page = (page == wrap_page) ? prch_pkg::PAGE_MIN : page + 8'h01;

  always_comb
  begin
    next_state = state;
    case (state)
      PRCH_IDLE:  if (req_ours) next_state = PRCH_WAIT;
      PRCH_WAIT:  if (waited) next_state = do_nak ? PRCH_IDLE : PRCH_FETCH;
      PRCH_FETCH: next_state = PRCH_PUSH;
      PRCH_PUSH:  if (fifo_ready) next_state = last_byte ? PRCH_DRAIN : PRCH_FETCH;
      PRCH_DRAIN: if (!fifo_valid && (!rsp_valid || rsp_ready)) next_state = PRCH_IDLE;
      default:    next_state = PRCH_IDLE;
    endcase
  end

  assign push = state == PRCH_PUSH;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state      <= PRCH_IDLE;
      page       <= '0;
      pages_left <= '0;
      byte_idx   <= '0;
      wrap_page  <= '0;
      do_nak     <= 1'b0;
      wait_cnt   <= '0;
      fetched    <= '0;
      nak_valid  <= 1'b0;
      deselect   <= 1'b0;
      mem_rd     <= 1'b0;
      busy       <= 1'b0;
      rsp_append_mac <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      busy      <= next_state != PRCH_IDLE;
      nak_valid <= state == PRCH_WAIT && waited && do_nak;
      deselect  <= state == PRCH_WAIT && waited && do_nak;
      mem_rd    <= next_state == PRCH_FETCH;
      wait_cnt  <= (state == PRCH_WAIT) ? wait_cnt + 24'h000001 : '0;
      if (req_ours)
      begin
        page       <= first_page_arg;
        pages_left <= cnt;
        byte_idx   <= '0;
        wrap_page  <= lim;
        do_nak     <= req_bad;
        rsp_append_mac <= secure_msg_enable;
      end
      if (state == PRCH_FETCH)
        fetched <= key_page ? 8'h00 : mem_rdata;
      if (push && fifo_ready)
      begin
        byte_idx <= byte_idx + 2'h1;
        if (byte_idx == 2'(prch_pkg::BYTES_PER_PAGE - 1))
        begin
          page       <= next_page;
          pages_left <= pages_left - 8'h01;
        end
      end
    end
  end

  // The last marker rides a side queue so the byte FIFO stays a plain data path.
  always_ff @(posedge clk_sys)
  begin
    if (push && fifo_ready)
      last_flag[lf_wr] <= last_byte;
    if (!reset_n)
    begin
      lf_wr <= '0;
      lf_rd <= '0;
    end
    else
    begin
      if (push && fifo_ready)
        lf_wr <= lf_wr + 3'h1;
      if (fifo_valid && !rsp_valid || rsp_valid && rsp_ready && fifo_valid)
        lf_rd <= lf_rd + 3'h1;
    end
  end

  assign last_byte_q = last_flag[lf_rd];

  // Output stage registers the FIFO head so every output except the constant nak_code comes from a flip-flop.
  wire take = fifo_valid && (!rsp_valid || rsp_ready);
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rsp_valid      <= 1'b0;
      rsp_data       <= '0;
      rsp_last       <= 1'b0;
      rsp_append_crc <= 1'b0;
    end
    else if (take)
    begin
      rsp_valid      <= 1'b1;
      rsp_data       <= fifo_data;
      rsp_last       <= last_byte_q;
      rsp_append_crc <= last_byte_q;
    end
    else if (rsp_ready)
    begin
      rsp_valid      <= 1'b0;
      rsp_last       <= 1'b0;
      rsp_append_crc <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      mem_page <= '0;
      mem_byte <= '0;
    end
    else
    begin
      // The address follows the counters as they will stand, so the fetch never lags a byte.
      mem_page <= (push && fifo_ready && byte_idx == 2'(prch_pkg::BYTES_PER_PAGE - 1))
                  ? next_page : page;
      mem_byte <= (push && fifo_ready) ? byte_idx + 2'h1 : byte_idx;
    end
  end

  assign nak_code = prch_pkg::NAK_CODE;

  prch_fifo #(
    .WIDTH (8),
    .DEPTH (prch_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (fetched),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (fifo_data)
  );
endmodule // prch_handler
`default_nettype wire

// ---- hw/prch_pkg.sv ----
// Purpose: Shared constants for the page read command handler.
// Assumes: Byte-wide request and response streams framed by the link layer.
// Notes:   Page numbers are one byte; each page holds four bytes.
`default_nettype none
package prch_pkg;
  localparam logic [7:0] OP_READ4      = 8'h30;
  localparam logic [7:0] OP_READ_RANGE = 8'h3a;
  localparam logic [7:0] PAGE_MIN      = 8'h00;
  localparam logic [7:0] PAGE_LAST     = 8'h3b;
  localparam int         BYTES_PER_PAGE = 4;
  localparam int         PAGES_READ4    = 4;
  localparam int         MAC_BYTES      = 8;
  localparam int         CRC_BYTES      = 2;
  localparam logic [3:0] NAK_CODE       = 4'h0;
  localparam int         FDT_BITS       = 9;
  localparam int         BIT_PERIOD_NS  = 9440;
  localparam int         CLK_PERIOD_NS  = 4;
  localparam int         FDT_CYCLES     = (FDT_BITS * BIT_PERIOD_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam int         FIFO_DEPTH     = 8;
  localparam logic [1:0] ST_ACTIVE      = 2'h0;
  localparam logic [1:0] ST_TRACEABLE   = 2'h1;
  localparam logic [1:0] ST_AUTH        = 2'h2;
endpackage
`default_nettype wire

// ---- hw/prch_fifo.sv ----
// Purpose: Small synchronous FIFO for response bytes.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Full and empty are exact; depth must be a power of two.
`default_nettype none
module prch_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // prch_fifo
`default_nettype wire

// ---- tb/prch_props.sv ----
// Purpose: Port checks for the page read handler.
// Assumes: Short reply delay of at least 8 cycles.
// Notes:   Bound from the bench top file.
`default_nettype none
module prch_props (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       busy,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_last,
  input wire logic       rsp_append_mac,
  input wire logic       rsp_append_crc,
  input wire logic       secure_msg_enable,
  input wire logic       nak_valid,
  input wire logic [3:0] nak_code,
  input wire logic       deselect
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  nak_deselect_a: assert property (nak_valid |-> deselect)
    else $error("nak without deselect");
  nak_code_a: assert property (nak_valid |-> nak_code == prch_pkg::NAK_CODE)
    else $error("wrong nak code");
  nak_alone_a: assert property (nak_valid |-> !rsp_valid [*8])
    else $error("data beside nak");
  last_crc_a: assert property (rsp_valid && rsp_last |-> rsp_append_crc)
    else $error("last byte without crc");
  mac_flag_a: assert property (rsp_valid |-> rsp_append_mac == secure_msg_enable)
    else $error("mac flag wrong");
  reply_gap_a: assert property ($rose(busy) |-> (!rsp_valid && !nak_valid) [*8])
    else $error("reply too early");
  reply_due_a: assert property ($rose(busy) |-> ##[1:60] (nak_valid || rsp_valid))
    else $error("no reply");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("byte dropped under stall");
endmodule // prch_props
`default_nettype wire

// ---- tb/prch_reader_model.sv ----
// Purpose: Far side: page memory and a stalling reader sink.
// Assumes: Read data is taken in the strobe cycle.
// Notes:   Off the strobe the bus shows the inverted pattern.
`default_nettype none
module prch_reader_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] mem_page,
  input  wire logic [1:0] mem_byte,
  input  wire logic       mem_rd,
  output logic      [7:0] mem_rdata,
  output logic            rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  assign mem_rdata = mem_rd ? {mem_page[5:0], mem_byte} : ~{mem_page[5:0], mem_byte};
  initial rsp_ready = 1'b0;
  // The sink takes a reply of any length; it only stalls now and then.
  always @(posedge clk_sys) rsp_ready <= ($urandom_range(3) != 0);
endmodule // prch_reader_model
`default_nettype wire

// ---- tb/prch_handler_bench.sv ----
// Purpose: Self-checking bench for the page read handler.
// Assumes: Reply delay 10 cycles; key pages 30h to 37h.
// Notes:   Stalls come from the far-side model.
`default_nettype none
module prch_handler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 0, reset_n = 0, req_valid = 0, req_mac_ok = 0;
  logic [7:0] req_opcode = 0, first_page_arg = 0, last_page_arg = 0;
  logic [1:0] proto_state = 0;
  logic       secure_msg_enable = 0;
  logic [7:0] protect_boundary_page = 8'hff;
  logic       busy, mem_rd, rsp_valid, rsp_ready, rsp_last, rsp_append_mac;
  logic       rsp_append_crc, nak_valid, deselect;
  logic [7:0] mem_page, mem_rdata, rsp_data;
  logic [1:0] mem_byte;
  logic [3:0] nak_code;
  int         error_cnt = 0;
  int         samples_checked = 0;
  initial forever #2 clk_sys = ~clk_sys;
  prch_handler #(.FDT_WAIT(10)) dut (.*);
  prch_reader_model peer (.*);
  function automatic logic [7:0] pat(int p, int b);
    return (p >= 'h30 && p <= 'h37) ? 8'h00 : {p[5:0], b[1:0]};
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, f, l, bnd, input logic [1:0] st,
                     input logic sme, mok);
    int lim;
    logic nak;
    logic got;
    logic seen;
    logic [7:0] q[$];
    lim = (st != prch_pkg::ST_AUTH && bnd <= 8'h3b) ? bnd : 'h3c;
    nak = sme && st != prch_pkg::ST_ACTIVE && !mok;
    got = 0;
    seen = 0;
    if (op == prch_pkg::OP_READ4)
    begin
      nak |= f >= lim;
      for (int i = 0; i < 16; i++) q.push_back(pat((f + i / 4) % lim, i % 4));
    end
    else if (op == prch_pkg::OP_READ_RANGE)
    begin
      nak |= l < f || l >= lim;
      for (int i = f * 4; i < l * 4 + 4; i++) q.push_back(pat(i / 4, i % 4));
    end
    if (nak) q.delete();
    @(posedge clk_sys);
    req_valid <= 1;
    req_opcode <= op;
    first_page_arg <= f;
    last_page_arg <= l;
    protect_boundary_page <= bnd;
    proto_state <= st;
    secure_msg_enable <= sme;
    req_mac_ok <= mok;
    @(posedge clk_sys);
    req_valid <= 0;
    for (int n = 0; n < 2000; n++)
    begin
      @(posedge clk_sys);
      seen |= busy;
      got |= nak_valid;
      if (rsp_valid && rsp_ready) chk(rsp_last, q.size() == 1);
      if (rsp_valid && rsp_ready) chk(rsp_data, q.size() ? q.pop_front() : ~rsp_data);
      if (!busy && (seen || n > 30)) break;
    end
    chk(got, nak);
    chk(q.size(), 0);
  endtask
  initial
  begin
    void'($urandom(32'hd4839b6f));
    repeat (20) @(posedge clk_sys);
    reset_n <= 1;
    run(prch_pkg::OP_READ4, 0, 0, 'hff, 0, 0, 0);
    run(prch_pkg::OP_READ4, 'h3a, 0, 'hff, 1, 0, 0);
    run(prch_pkg::OP_READ4, 'h3c, 0, 'hff, 0, 0, 0);
    run(prch_pkg::OP_READ4, 'h10, 0, 'h12, 0, 0, 0);
    run(prch_pkg::OP_READ4, 'h12, 0, 'h12, 1, 0, 0);
    run(prch_pkg::OP_READ4, 'h12, 0, 'h12, 2, 0, 0);
    run(prch_pkg::OP_READ4, 0, 0, 'hff, 1, 1, 0);
    run(prch_pkg::OP_READ4, 0, 0, 'hff, 2, 1, 1);
    run(prch_pkg::OP_READ_RANGE, 'h2e, 'h39, 'hff, 0, 0, 0);
    run(prch_pkg::OP_READ_RANGE, 5, 4, 'hff, 0, 0, 0);
    run(prch_pkg::OP_READ_RANGE, 0, 'h3c, 'hff, 0, 0, 0);
    run(prch_pkg::OP_READ_RANGE, 5, 'h12, 'h12, 0, 0, 0);
    run(prch_pkg::OP_READ_RANGE, 5, 'h12, 'h12, 2, 0, 0);
    run(prch_pkg::OP_READ_RANGE, 0, 'h3b, 'hff, 2, 0, 0);
    run(prch_pkg::OP_READ_RANGE, 0, 1, 'hff, 1, 1, 0);
    run(8'h31, 0, 0, 'hff, 0, 0, 0);
    repeat (8) run($urandom_range(1) ? prch_pkg::OP_READ4 : prch_pkg::OP_READ_RANGE,
                   8'($urandom_range(63)), 8'($urandom_range(63)), 8'($urandom_range(255, 1)),
                   2'($urandom_range(2)), 1'($urandom_range(1)), 1'($urandom_range(1)));
    print_verdict();
  end
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule // prch_handler_bench
bind prch_handler prch_props u_props (.clk_sys(clk_sys), .reset_n(reset_n), .busy(busy),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_last(rsp_last),
  .rsp_append_mac(rsp_append_mac), .rsp_append_crc(rsp_append_crc),
  .secure_msg_enable(secure_msg_enable), .nak_valid(nak_valid), .nak_code(nak_code),
  .deselect(deselect));
`default_nettype wire
